// ---- rtl/mgpa_top.sv ----
/*
  Port 1 and port 3 GPIO with alternate functions: serial pins, interrupt
  inputs, timer event/gate/trigger pins and emulator strobes, on APB.
  Assumes pins synchronous to clock and a zero-wait APB master.
*/
`timescale 1ns/100ps

// Operation
// - Each pad combines in and out; enable low drives, high listens.
// - Pins sink low actively; high held by weak pullup after boost.
// - Pad enable is data ANDed with data delayed two clocks.
// - Per-port control bits turn pullups off; high then floats.
// - After reset all pins are inputs with pullups on.
// - Port 3 bits 0 and 1 are already inputs in reset and stay so while serial is idle.
// - Port 3 bits 0 to 5 output alternate output ANDed with latch; idle alternate 1.
// - Alternate inputs go straight to core; pins stay readable.
// - Serial mode 0: data on bit 0, clock/12 shift clock on bit 1.
// - Modes 1 to 3: receive on bit 0, transmit on bit 1, concurrent.
// - Any serial buffer access while idle starts sending; otherwise outputs stay 1.
// - Receiver works only while receive enable is set.
// - Port 3 bit 2 feeds shared interrupt, bit 3 dedicated interrupt.
// - Three 16-bit timers count once per twelve clocks in timer mode.
// - Counter mode counts falling edges on P3.4, P3.5, P1.0.
// - Timer 1 gated by port 3 bit 3; timer 0 never gated.
// - Port 1 bit 1 trigger captures in counter, reloads in timer mode.
// - Ext select: bits 7,6 take emulator strobes; else output core strobes.
module mgpa_top (
  input wire logic clock,
  input wire logic rst,
  input mgpa_pkg::mgpa_apb_req_t apbReq,
  output mgpa_pkg::mgpa_apb_rsp_t apbRsp,
  input wire logic [7:0] port1In,
  input wire logic [7:0] port3In,
  output mgpa_pkg::mgpa_pad_t port1Pad,
  output mgpa_pkg::mgpa_pad_t port3Pad,
  input wire logic coreReadStrobeN,
  input wire logic coreWriteStrobeN,
  output logic emuReadStrobeN,
  output logic emuWriteStrobeN,
  output logic sharedInterrupt,
  output logic dedicatedInterrupt
);
  typedef struct packed {
    logic [7:0] p1Latch;
    logic [7:0] p3Latch;
    logic [15:0] ctrl;
    logic [2:0][15:0] tmr;
    logic [15:0] t2Reload;
    logic [15:0] t2Capture;
    logic [2:0] evPrev;
    logic trigPrev;
    logic [3:0] flags;
    logic [7:0] txHold;
    logic [9:0] txShift;
    logic [3:0] txCount;
    mgpa_pkg::mgpa_rxstate_t rxState;
    logic [2:0] rxCount;
    logic [7:0] rxShift;
    logic [7:0] rxData;
    logic [31:0] prdata;
    logic pslverr;
  } mgpa_top_state_t;

  localparam mgpa_top_state_t ST_RESET = '{
    p1Latch: mgpa_pkg::RST_LATCH,
    p3Latch: mgpa_pkg::RST_LATCH,
    ctrl: mgpa_pkg::RST_CTRL,
    tmr: {3{mgpa_pkg::RST_WORD}},
    t2Reload: mgpa_pkg::RST_WORD,
    t2Capture: mgpa_pkg::RST_WORD,
    evPrev: 3'h7,
    trigPrev: 1'b1,
    flags: 4'h0,
    txHold: 8'hFF,
    txShift: 10'h3FF,
    txCount: 4'h0,
    rxState: mgpa_pkg::MGPA_RX_IDLE,
    rxCount: 3'h0,
    rxShift: 8'h00,
    rxData: 8'h00,
    prdata: 32'h0000_0000,
    pslverr: 1'b0
  };

  mgpa_top_state_t st;
  mgpa_top_state_t next_st;
  logic machCycle;
  logic shiftLow;
  logic [7:0] alt3;
  logic [7:0] p3Data;
  logic setup;
  logic access;
  logic wrAccess;
  logic serAccess;
  logic extSel;
  logic rxEnable;
  logic modeZero;
  logic txBusy;
  logic [2:0] evNow;
  logic [2:0] tmrWrite;

  function automatic logic isAt(input logic [7:0] addr,
                                input logic [7:0] off);
    isAt = (addr == off);
  endfunction : isAt

  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = isAt(addr, mgpa_pkg::OFF_P1_LATCH)
      || isAt(addr, mgpa_pkg::OFF_P3_LATCH)
      || isAt(addr, mgpa_pkg::OFF_PINS)
      || isAt(addr, mgpa_pkg::OFF_CTRL)
      || isAt(addr, mgpa_pkg::OFF_SERBUF)
      || isAt(addr, mgpa_pkg::OFF_STATUS)
      || isAt(addr, mgpa_pkg::OFF_TMR0)
      || isAt(addr, mgpa_pkg::OFF_TMR1)
      || isAt(addr, mgpa_pkg::OFF_TMR2)
      || isAt(addr, mgpa_pkg::OFF_T2_RELOAD);
  endfunction : isMapped

  // ==========================================================
  // Submodules
  mgpa_mach_div u_div (
    .clock(clock),
    .rst(rst),
    .machCycle(machCycle),
    .shiftLow(shiftLow)
  );
  mgpa_pad_bank u_port1 (
    .clock(clock),
    .rst(rst),
    .dataOut(st.p1Latch),
    .pullupDisable(st.ctrl[mgpa_pkg::CB_P1_PUDIS]),
    .pad(port1Pad)
  );
  mgpa_pad_bank u_port3 (
    .clock(clock),
    .rst(rst),
    .dataOut(p3Data),
    .pullupDisable(st.ctrl[mgpa_pkg::CB_P3_PUDIS]),
    .pad(port3Pad)
  );

  // ==========================================================
  // Decodes and pin routing
  assign setup = apbReq.psel & ~apbReq.penable;
  assign access = apbReq.psel & apbReq.penable;
  assign wrAccess = access & apbReq.pwrite;
  assign serAccess = access & isAt(apbReq.paddr, mgpa_pkg::OFF_SERBUF);
  assign extSel = st.ctrl[mgpa_pkg::CB_EXT_MCU];
  assign rxEnable = st.ctrl[mgpa_pkg::CB_RX_EN];
  assign modeZero = (st.ctrl[mgpa_pkg::CB_SER_MODE +: 2] ==
                     mgpa_pkg::MGPA_SER_M0);
  assign txBusy = (st.txCount != 4'h0);
  assign evNow = {port1In[0], port3In[5], port3In[4]};
  assign tmrWrite = {wrAccess & isAt(apbReq.paddr, mgpa_pkg::OFF_TMR2),
                     wrAccess & isAt(apbReq.paddr, mgpa_pkg::OFF_TMR1),
                     wrAccess & isAt(apbReq.paddr, mgpa_pkg::OFF_TMR0)};

  // Alternate outputs rest at 1 while the serial unit is idle
  always_comb begin
    alt3 = 8'hFF;
    if (txBusy && modeZero) begin
      alt3[0] = st.txShift[0];
      alt3[1] = ~shiftLow;
    end else if (txBusy) begin
      alt3[1] = st.txShift[0];
    end
  end
  always_comb begin
    p3Data = st.p3Latch & alt3;
    p3Data[6] = extSel ? 1'b1 : coreWriteStrobeN;
    p3Data[7] = extSel ? 1'b1 : coreReadStrobeN;
  end
  assign sharedInterrupt = port3In[2];
  assign dedicatedInterrupt = port3In[3];
  assign emuWriteStrobeN = extSel ? port3In[6] : 1'b1;
  assign emuReadStrobeN = extSel ? port3In[7] : 1'b1;
  assign apbRsp.prdata = st.prdata;
  assign apbRsp.pready = 1'b1;
  assign apbRsp.pslverr = st.pslverr;

  // ==========================================================
  // Next state
  always_comb begin
    logic [3:0] setFlags;
    logic [3:0] clrFlags;
    logic tmrRun;
    logic tick;
    logic trigFall;
    setFlags = 4'h0;
    clrFlags = 4'h0;
    tmrRun = 1'b0;
    tick = 1'b0;
    trigFall = 1'b0;
    next_st = st;

    // Register writes at the access edge
    if (wrAccess) begin
      if (isAt(apbReq.paddr, mgpa_pkg::OFF_P1_LATCH)) begin
        next_st.p1Latch = apbReq.pwdata[7:0];
      end
      if (isAt(apbReq.paddr, mgpa_pkg::OFF_P3_LATCH)) begin
        next_st.p3Latch = apbReq.pwdata[7:0];
      end
      if (isAt(apbReq.paddr, mgpa_pkg::OFF_CTRL)) begin
        next_st.ctrl = apbReq.pwdata[15:0];
      end
      if (isAt(apbReq.paddr, mgpa_pkg::OFF_STATUS)) begin
        clrFlags = apbReq.pwdata[3:0];
      end
      if (isAt(apbReq.paddr, mgpa_pkg::OFF_T2_RELOAD)) begin
        next_st.t2Reload = apbReq.pwdata[15:0];
      end
      if (isAt(apbReq.paddr, mgpa_pkg::OFF_SERBUF)) begin
        next_st.txHold = apbReq.pwdata[7:0];
      end
    end

    // Transmitter: any buffer access while idle starts a frame
    if (serAccess && !txBusy) begin
      if (modeZero) begin
        next_st.txShift = {2'b11, next_st.txHold};
        next_st.txCount = 4'(mgpa_pkg::M0_BITS);
      end else begin
        next_st.txShift = {1'b1, next_st.txHold, 1'b0};
        next_st.txCount = 4'(mgpa_pkg::FRAME_BITS);
      end
    end else if (machCycle && txBusy) begin
      next_st.txShift = {1'b1, st.txShift[9:1]};
      next_st.txCount = st.txCount - 4'h1;
    end

    // Receiver, modes 1 to 3, sampled once per machine cycle
    if (!rxEnable || modeZero) begin
      next_st.rxState = mgpa_pkg::MGPA_RX_IDLE;
    end else if (machCycle) begin
      case (st.rxState)
        mgpa_pkg::MGPA_RX_IDLE: begin
          if (!port3In[0]) begin
            next_st.rxState = mgpa_pkg::MGPA_RX_DATA;
            next_st.rxCount = 3'h0;
          end
        end
        mgpa_pkg::MGPA_RX_DATA: begin
          next_st.rxShift = {port3In[0], st.rxShift[7:1]};
          next_st.rxCount = st.rxCount + 3'h1;
          if (st.rxCount == 3'h7) begin
            next_st.rxState = mgpa_pkg::MGPA_RX_STOP;
          end
        end
        mgpa_pkg::MGPA_RX_STOP: begin
          if (port3In[0]) begin
            next_st.rxData = st.rxShift;
            setFlags[mgpa_pkg::SB_RX_DONE] = 1'b1;
          end
          next_st.rxState = mgpa_pkg::MGPA_RX_IDLE;
        end
        default: begin
          next_st.rxState = mgpa_pkg::MGPA_RX_IDLE;
        end
      endcase
    end

    // Timers and event pins
    if (machCycle) begin
      next_st.evPrev = evNow;
      next_st.trigPrev = port1In[1];
      trigFall = st.trigPrev & ~port1In[1];
    end
    for (int i = 0; i < 3; i++) begin
      tmrRun = st.ctrl[mgpa_pkg::CB_T0_RUN + i];
      if (i == 1 && st.ctrl[mgpa_pkg::CB_T1_GATE]) begin
        tmrRun = tmrRun & port3In[3];
      end
      if (st.ctrl[mgpa_pkg::CB_T0_COUNTER + i]) begin
        tick = machCycle & st.evPrev[i] & ~evNow[i];
      end else begin
        tick = machCycle;
      end
      if (tmrWrite[i]) begin
        next_st.tmr[i] = apbReq.pwdata[15:0];
      end else if (tmrRun && tick) begin
        next_st.tmr[i] = st.tmr[i] + 16'h0001;
        if (st.tmr[i] == 16'hFFFF) begin
          setFlags[mgpa_pkg::SB_OVF0 + i] = 1'b1;
        end
      end
    end
    if (trigFall && st.ctrl[mgpa_pkg::CB_T2_EXT_EN] && !tmrWrite[2]) begin
      if (st.ctrl[mgpa_pkg::CB_T0_COUNTER + 2]) begin
        next_st.t2Capture = st.tmr[2];
      end else begin
        next_st.tmr[2] = st.t2Reload;
      end
    end

    // Sticky flags: a set in the clearing cycle survives
    next_st.flags = (st.flags & ~clrFlags) | setFlags;

    // Read data and error captured in the setup cycle
    if (setup) begin
      next_st.pslverr = ~isMapped(apbReq.paddr);
      next_st.prdata = 32'h0000_0000;
      case (apbReq.paddr)
        mgpa_pkg::OFF_P1_LATCH: next_st.prdata[7:0] = st.p1Latch;
        mgpa_pkg::OFF_P3_LATCH: next_st.prdata[7:0] = st.p3Latch;
        mgpa_pkg::OFF_PINS: next_st.prdata[15:0] = {port3In, port1In};
        mgpa_pkg::OFF_CTRL: next_st.prdata[15:0] = st.ctrl;
        mgpa_pkg::OFF_SERBUF: next_st.prdata[7:0] = st.rxData;
        mgpa_pkg::OFF_STATUS: begin
          next_st.prdata[3:0] = st.flags;
          next_st.prdata[mgpa_pkg::SB_TX_BUSY] = txBusy;
          next_st.prdata[mgpa_pkg::SB_RX_BUSY] =
            (st.rxState != mgpa_pkg::MGPA_RX_IDLE);
        end
        mgpa_pkg::OFF_TMR0: next_st.prdata[15:0] = st.tmr[0];
        mgpa_pkg::OFF_TMR1: next_st.prdata[15:0] = st.tmr[1];
        mgpa_pkg::OFF_TMR2: next_st.prdata[15:0] = st.tmr[2];
        mgpa_pkg::OFF_T2_RELOAD: next_st.prdata[15:0] = st.t2Capture;
        default: next_st.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  a_tx_idle_high: assert property (!txBusy |-> alt3 == 8'hFF)
    else $error("serial alternate not idle high");
  a_tx_start: assert property (serAccess && !txBusy |=> txBusy)
    else $error("buffer access did not start send");
  a_rx_blocked: assert property (!rxEnable |=>
    st.rxState == mgpa_pkg::MGPA_RX_IDLE)
    else $error("receiver active while disabled");
  a_emu_inputs: assert property (extSel |-> p3Data[7:6] == 2'b11)
    else $error("emulator strobe pins driven");
  a_p3_and: assert property (p3Data[5:0] == (st.p3Latch[5:0] & alt3[5:0]))
    else $error("port 3 data not latch AND alternate");
  a_t0_step: assert property (machCycle && st.ctrl[mgpa_pkg::CB_T0_RUN]
    && !st.ctrl[mgpa_pkg::CB_T0_COUNTER] && !tmrWrite[0]
    |=> st.tmr[0] == $past(st.tmr[0]) + 16'h0001)
    else $error("timer 0 missed a machine cycle");
  a_t1_gated: assert property (st.ctrl[mgpa_pkg::CB_T1_GATE]
    && !port3In[3] && !tmrWrite[1] |=> $stable(st.tmr[1]))
    else $error("timer 1 ran with gate low");
  a_t0_idle: assert property (!machCycle && !tmrWrite[0]
    |=> $stable(st.tmr[0]))
    else $error("timer 0 moved off machine cycle");
  c_mode0_tx: cover property (serAccess && modeZero ##1 txBusy);
  c_rx_done: cover property ($rose(st.flags[mgpa_pkg::SB_RX_DONE]));
  c_t2_trig: cover property (machCycle && st.trigPrev && !port1In[1]
    && st.ctrl[mgpa_pkg::CB_T2_EXT_EN]);
endmodule : mgpa_top

// ---- inc/mgpa_pkg.sv ----
/*
  Shared constants, register map and carrier types for the GPIO port block.
  Assumes a single 40 MHz clock and an APB master with 8-bit addressing.
*/
package mgpa_pkg;
  // ==========================================================
  // Timing
  localparam int MACH_DIV = 12;
  localparam int SHIFT_LOW = 6;
  localparam int M0_BITS = 8;
  localparam int FRAME_BITS = 10;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_P1_LATCH = 8'h00;
  localparam logic [7:0] OFF_P3_LATCH = 8'h04;
  localparam logic [7:0] OFF_PINS = 8'h08;
  localparam logic [7:0] OFF_CTRL = 8'h0C;
  localparam logic [7:0] OFF_SERBUF = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_TMR0 = 8'h18;
  localparam logic [7:0] OFF_TMR1 = 8'h1C;
  localparam logic [7:0] OFF_TMR2 = 8'h20;
  localparam logic [7:0] OFF_T2_RELOAD = 8'h24;

  // ==========================================================
  // Control field positions
  localparam int CB_P1_PUDIS = 0;
  localparam int CB_P3_PUDIS = 1;
  localparam int CB_EXT_MCU = 2;
  localparam int CB_SER_MODE = 3;
  localparam int CB_RX_EN = 5;
  localparam int CB_T0_COUNTER = 6;
  localparam int CB_T1_GATE = 9;
  localparam int CB_T2_EXT_EN = 10;
  localparam int CB_T0_RUN = 11;

  // Status field positions
  localparam int SB_RX_DONE = 0;
  localparam int SB_OVF0 = 1;
  localparam int SB_TX_BUSY = 4;
  localparam int SB_RX_BUSY = 5;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_LATCH = 8'hFF;
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef enum logic [1:0] {
    MGPA_SER_M0 = 2'b00,
    MGPA_SER_M1 = 2'b01,
    MGPA_SER_M2 = 2'b10,
    MGPA_SER_M3 = 2'b11
  } mgpa_sermode_t;

  typedef enum logic [1:0] {
    MGPA_RX_IDLE = 2'b00,
    MGPA_RX_DATA = 2'b01,
    MGPA_RX_STOP = 2'b10
  } mgpa_rxstate_t;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } mgpa_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mgpa_apb_rsp_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pullupOn;
  } mgpa_pad_t;
endpackage : mgpa_pkg

// ---- rtl/mgpa_mach_div.sv ----
/*
  Machine-cycle divider: one-cycle enable every twelve clocks, plus the
  low half of the serial shift clock.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/100ps
module mgpa_mach_div (
  input wire logic clock,
  input wire logic rst,
  output logic machCycle,
  output logic shiftLow
);
  typedef struct packed {
    logic [3:0] cnt;
  } mgpa_div_state_t;

  mgpa_div_state_t st;
  mgpa_div_state_t next_st;

  // ==========================================================
  // Counter
  always_comb begin
    next_st = st;
    if (st.cnt == 4'(mgpa_pkg::MACH_DIV - 1)) begin
      next_st.cnt = 4'h0;
    end else begin
      next_st.cnt = st.cnt + 4'h1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign machCycle = (st.cnt == 4'(mgpa_pkg::MACH_DIV - 1));
  assign shiftLow = (st.cnt < 4'(mgpa_pkg::SHIFT_LOW));

  // ==========================================================
  // Checks
  a_mach_period: assert property (@(posedge clock) disable iff (rst)
    machCycle |-> ##12 machCycle) else $error("machine cycle not 12");
  a_mach_gap: assert property (@(posedge clock) disable iff (rst)
    machCycle |=> !machCycle [*8]) else $error("machine cycle too soon");
endmodule : mgpa_mach_div

// ---- rtl/mgpa_pad_bank.sv ----
/*
  Eight quasi-bidirectional pad drivers with two-clock strong high drive.
  Assumes the pad wire resolves out/oe/pullupOn outside the design.
*/
`timescale 1ns/100ps
module mgpa_pad_bank (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] dataOut,
  input wire logic pullupDisable,
  output mgpa_pkg::mgpa_pad_t pad
);
  typedef struct packed {
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] d2;
  } mgpa_pad_state_t;

  mgpa_pad_state_t st;
  mgpa_pad_state_t next_st;

  // ==========================================================
  // Output data and its two-clock delayed copy
  always_comb begin
    next_st = st;
    next_st.d0 = dataOut;
    next_st.d1 = st.d0;
    next_st.d2 = st.d1;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '{d0: mgpa_pkg::RST_LATCH, d1: mgpa_pkg::RST_LATCH,
              d2: mgpa_pkg::RST_LATCH};
    end else begin
      st <= next_st;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      logic padEnable;
      // Low enable drives the pin, high enable listens
      assign padEnable = st.d0[i] & st.d2[i];
      assign pad.oe[i] = ~padEnable;
      assign pad.out[i] = st.d0[i];
      assign pad.pullupOn[i] = ~pullupDisable;

      a_low_sinks: assert property (@(posedge clock) disable iff (rst)
        !st.d0[i] |-> pad.oe[i] && !pad.out[i])
        else $error("low level not driven");
      a_strong_two: assert property (@(posedge clock) disable iff (rst)
        $rose(st.d0[i]) && !$past(st.d0[i], 2)
        |-> pad.oe[i] ##1 pad.oe[i])
        else $error("strong high too short");
      a_strong_end: assert property (@(posedge clock) disable iff (rst)
        $rose(st.d0[i]) ##1 st.d0[i] ##1 st.d0[i] |-> !pad.oe[i])
        else $error("strong high too long");
    end
  endgenerate

  c_rise: cover property (@(posedge clock) disable iff (rst)
    $rose(st.d0[0]) ##2 !pad.oe[0]);
endmodule : mgpa_pad_bank

// ---- bench/mgpa_pin_model.sv ----
/*
  Outside world of one port: resolves each wire from pad drive, weak
  pullup and an outside driver. Assumes the design's clock.
*/
`timescale 1ns/100ps
module mgpa_pin_model (
  input wire logic clock,
  input mgpa_pkg::mgpa_pad_t pad,
  input wire logic [7:0] extVal,
  input wire logic [7:0] extOe,
  output logic [7:0] pinLevel
);
  logic [7:0] lastLevel;
  always_ff @(posedge clock) lastLevel <= pinLevel;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad.oe[i])
        pinLevel[i] = pad.out[i];
      else if (extOe[i])
        pinLevel[i] = extVal[i];
      else if (pad.pullupOn[i])
        pinLevel[i] = 1'b1;
      // Floating wire: no stable level to trust
      else
        pinLevel[i] = ~lastLevel[i];
    end
  end
endmodule : mgpa_pin_model

// ---- bench/mgpa_top_test.sv ----
/*
  Directed bench for the GPIO ports: APB tasks, pad walks, alternates.
  Assumes pready answers in the access cycle or later.
*/
`timescale 1ns/100ps
module mgpa_top_test;
  logic clock;
  logic rst;
  mgpa_pkg::mgpa_apb_req_t apbReq;
  mgpa_pkg::mgpa_apb_rsp_t apbRsp;
  mgpa_pkg::mgpa_pad_t port1Pad;
  mgpa_pkg::mgpa_pad_t port3Pad;
  logic [7:0] port1In;
  logic [7:0] port3In;
  logic [7:0] ext1Oe;
  logic [7:0] ext3Val;
  logic [7:0] ext3Oe;
  logic coreReadStrobeN;
  logic coreWriteStrobeN;
  logic emuReadStrobeN;
  logic emuWriteStrobeN;
  logic sharedInterrupt;
  logic dedicatedInterrupt;
  logic lastErr;
  logic [31:0] rd;
  logic [31:0] t0;
  int c;
  int n_mismatch;
  int checks;

  mgpa_top dut_u (.clock(clock), .rst(rst), .apbReq(apbReq),
    .apbRsp(apbRsp), .port1In(port1In), .port3In(port3In),
    .port1Pad(port1Pad), .port3Pad(port3Pad),
    .coreReadStrobeN(coreReadStrobeN), .coreWriteStrobeN(coreWriteStrobeN),
    .emuReadStrobeN(emuReadStrobeN), .emuWriteStrobeN(emuWriteStrobeN),
    .sharedInterrupt(sharedInterrupt),
    .dedicatedInterrupt(dedicatedInterrupt));
  mgpa_pin_model pin1_u (.clock(clock), .pad(port1Pad), .extVal(8'h00),
    .extOe(ext1Oe), .pinLevel(port1In));
  mgpa_pin_model pin3_u (.clock(clock), .pad(port3Pad), .extVal(ext3Val),
    .extOe(ext3Oe), .pinLevel(port3In));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ==========================================================
  // Tasks
  task automatic print_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    int k;
    @(posedge clock);
    apbReq <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clock);
    apbReq.penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge clock);
      if (apbRsp.pready === 1'b1)
        break;
    end
    if (k == 20)
      chk("pready", 32'h0, 32'h1);
    if (k == 20)
      print_verdict();
    rd = apbRsp.prdata;
    lastErr = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : xfer

  task automatic wait_tx(input logic v);
    for (c = 0; c < 40; c++) begin
      @(negedge clock);
      if (port3Pad.out[1] === v)
        break;
    end
    if (c == 40)
      chk("tx pin wait", 32'h0, 32'h1);
    if (c == 40)
      print_verdict();
  endtask : wait_tx

  // ==========================================================
  // Sequence
  initial begin
    apbReq = '0;
    ext1Oe = 8'h00;
    ext3Val = 8'hFF;
    ext3Oe = 8'h00;
    coreReadStrobeN = 1'b1;
    coreWriteStrobeN = 1'b1;
    rst = 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk("p1 pad", 32'(port1Pad), 32'h00FF00FF);
    chk("p3 pad", 32'(port3Pad), 32'h00FF00FF);
    xfer(mgpa_pkg::OFF_P1_LATCH, 1'b0, 32'h0);
    chk("p1 latch", rd, 32'h000000FF);
    xfer(mgpa_pkg::OFF_P1_LATCH, 1'b1, 32'h0);
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk("p1 sink", 32'({port1Pad.oe, port1In}), 32'h0000FF00);
    xfer(mgpa_pkg::OFF_P1_LATCH, 1'b1, 32'hFF);
    @(posedge clock);
    for (int k = 0; k < 3; k++) begin
      @(negedge clock);
      chk("boost", 32'(port1Pad.oe), (k < 2) ? 32'hFF : 32'h0);
    end
    chk("p1 high", 32'(port1In), 32'h000000FF);
    // Interrupt pins pulled low from outside
    @(posedge clock);
    ext3Oe <= 8'h0C;
    ext3Val <= 8'h00;
    @(negedge clock);
    chk("irq", 32'({sharedInterrupt, dedicatedInterrupt}), 32'h0);
    xfer(mgpa_pkg::OFF_PINS, 1'b0, 32'h0);
    chk("pins", rd, 32'h0000F3FF);
    xfer(mgpa_pkg::OFF_CTRL, 1'b1, 32'h1 << mgpa_pkg::CB_P1_PUDIS);
    @(posedge clock);
    @(negedge clock);
    chk("pullups", 32'({port1Pad.pullupOn, port3Pad.pullupOn}),
        32'h000000FF);
    // Emulator strobes
    xfer(mgpa_pkg::OFF_CTRL, 1'b1, 32'h1 << mgpa_pkg::CB_EXT_MCU);
    ext3Oe <= 8'hC0;
    ext3Val <= 8'h40;
    @(negedge clock);
    chk("emu in", 32'({emuReadStrobeN, emuWriteStrobeN}), 32'h1);
    xfer(mgpa_pkg::OFF_CTRL, 1'b1, 32'h0);
    ext3Oe <= 8'h00;
    coreReadStrobeN <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk("emu idle", 32'({emuReadStrobeN, emuWriteStrobeN}), 32'h3);
    chk("core out", 32'(port3Pad.out[7:6]), 32'h1);
    @(posedge clock);
    coreReadStrobeN <= 1'b1;
    coreWriteStrobeN <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chk("core write", 32'(port3Pad.out[7:6]), 32'h2);
    @(posedge clock);
    coreWriteStrobeN <= 1'b1;
    xfer(8'h3C, 1'b0, 32'h0);
    chk("unmapped", {31'h0, lastErr}, 32'h1);
    // Timer 0: 120 clocks between snapshots
    xfer(mgpa_pkg::OFF_CTRL, 1'b1, 32'h1 << mgpa_pkg::CB_T0_RUN);
    xfer(mgpa_pkg::OFF_TMR0, 1'b0, 32'h0);
    t0 = rd;
    repeat (117) @(posedge clock);
    xfer(mgpa_pkg::OFF_TMR0, 1'b0, 32'h0);
    chk("t0 rate", (rd - t0) & 32'hFFFF, 32'h0000000A);
    xfer(mgpa_pkg::OFF_CTRL, 1'b1, (32'h1 << mgpa_pkg::CB_T0_RUN)
         | (32'h1 << mgpa_pkg::CB_T0_COUNTER));
    ext3Oe <= 8'h10;
    ext3Val <= 8'hFF;
    xfer(mgpa_pkg::OFF_TMR0, 1'b0, 32'h0);
    t0 = rd;
    for (int k = 0; k < 6; k++) begin
      ext3Val[4] <= k[0];
      repeat (24) @(posedge clock);
    end
    xfer(mgpa_pkg::OFF_TMR0, 1'b0, 32'h0);
    chk("t0 events", (rd - t0) & 32'hFFFF, 32'h3);
    // Timer 1 held by a low gate pin, then free to run
    ext3Oe <= 8'h08;
    ext3Val <= 8'h00;
    xfer(mgpa_pkg::OFF_CTRL, 1'b1, (32'h1 << (mgpa_pkg::CB_T0_RUN + 1))
         | (32'h1 << mgpa_pkg::CB_T1_GATE));
    for (int g = 0; g < 2; g++) begin
      xfer(mgpa_pkg::OFF_TMR1, 1'b0, 32'h0);
      t0 = rd;
      repeat (117) @(posedge clock);
      xfer(mgpa_pkg::OFF_TMR1, 1'b0, 32'h0);
      chk("t1 gate", (rd - t0) & 32'hFFFF, g ? 32'hA : 32'h0);
      ext3Oe <= 8'h00;
    end
    // Timer 2 reloaded by a falling trigger pin
    xfer(mgpa_pkg::OFF_T2_RELOAD, 1'b1, 32'h1200);
    xfer(mgpa_pkg::OFF_CTRL, 1'b1, (32'h1 << (mgpa_pkg::CB_T0_RUN + 2))
         | (32'h1 << mgpa_pkg::CB_T2_EXT_EN));
    ext1Oe <= 8'h02;
    repeat (24) @(posedge clock);
    ext1Oe <= 8'h00;
    repeat (24) @(posedge clock);
    xfer(mgpa_pkg::OFF_TMR2, 1'b0, 32'h0);
    chk("t2 reload", rd & 32'hFF00, 32'h1200);
    // Serial: every mode starts a frame on a buffer write
    chk("tx idle", 32'(port3Pad.out[1:0]), 32'h3);
    for (int m = 0; m < 4; m++) begin
      xfer(mgpa_pkg::OFF_CTRL, 1'b1, 32'(m) << mgpa_pkg::CB_SER_MODE);
      xfer(mgpa_pkg::OFF_SERBUF, 1'b1, 32'h0);
      wait_tx(1'b0);
      if (m == 0) begin
        wait_tx(1'b1);
        wait_tx(1'b0);
        chk("shift high", 32'(c), 32'h5);
      end
      repeat (150) @(posedge clock);
      chk("tx rest", 32'(port3Pad.out[1:0]), 32'h3);
    end
    xfer(mgpa_pkg::OFF_CTRL, 1'b1, 32'h1 << mgpa_pkg::CB_SER_MODE);
    ext3Oe <= 8'h01;
    ext3Val <= 8'h00;
    repeat (150) @(posedge clock);
    xfer(mgpa_pkg::OFF_STATUS, 1'b0, 32'h0);
    chk("rx off", rd & 32'h21, 32'h0);
    // Receive one frame: start, 8'hA5 LSB first, stop
    ext3Val <= 8'hFF;
    xfer(mgpa_pkg::OFF_CTRL, 1'b1, (32'h1 << mgpa_pkg::CB_SER_MODE)
         | (32'h1 << mgpa_pkg::CB_RX_EN));
    for (int k = 0; k < 10; k++) begin
      ext3Val[0] <= 1'(10'h34A >> k);
      repeat (12) @(posedge clock);
    end
    xfer(mgpa_pkg::OFF_STATUS, 1'b0, 32'h0);
    chk("rx done", rd & 32'h21, 32'h1);
    xfer(mgpa_pkg::OFF_SERBUF, 1'b0, 32'h0);
    chk("rx byte", rd, 32'h000000A5);
    print_verdict();
  end
endmodule : mgpa_top_test
